// ### hdl/acc_converter_ctrl.v
// Converter control: channel select, repeating successive approximation,
// result register, and port 0 comparator inputs.
// Assumes the core issues one-cycle instruction strobes on clk_in and that
// the analog front end supplies one comparator decision bit per trial.
//
// Notes on behaviour
// - Two multiplexed analog channels, chosen by one select strobe each.
// - Conversion is a hardware successive-approximation sequence; software only selects/reads.
// - Conversions repeat; any select aborts and restarts on the new channel.
// - A select leaves the result register unchanged.
// - First result fourth instruction cycle after select, then every four.
// - Read returns the result register without disturbing conversion.
// - Results are unsigned eight-bit values.
// - Each port 0 line has its own comparator against one shared reference.
// - A port 0 line reads 1 when pin exceeds reference, else 0.
// - Instruction cycle is ten microseconds; conversion timing counts these cycles and their halves.
`timescale 1ns/1ps
`include "acc_map.vh"
`default_nettype none

module acc_converter_ctrl #(
   parameter INSTR_CYCLE_CLKS = `ACC_INSTR_CYCLE_CLKS,
   parameter RESULT_WIDTH     = `ACC_RESULT_WIDTH,
   parameter PORT0_WIDTH      = `ACC_PORT0_WIDTH
) (
   // Clock and reset
   input  wire                    clk_in,
   input  wire                    reset_in,
   // Instruction strobes from the core
   input  wire                    choose_analog_input_zero_in,
   input  wire                    choose_analog_input_one_in,
   input  wire                    read_conversion_instr_in,
   // Analog front end
   input  wire                    ladder_above_input_in,
   output reg                     channel_select_out,
   output reg                     sample_out,
   output reg  [RESULT_WIDTH-1:0] ladder_code_out,
   // Port 0 comparator decisions, one per line
   input  wire [PORT0_WIDTH-1:0]  port0_above_ref_in,
   output reg  [PORT0_WIDTH-1:0]  port0_data_out,
   // Results to the core
   output reg  [RESULT_WIDTH-1:0] conversion_result_reg_out,
   output reg  [RESULT_WIDTH-1:0] accumulator_data_out,
   output reg                     accumulator_load_out,
   output reg                     result_fresh_out
);

   // ==========================================================
   // State encoding
   localparam [2:0] ST_IDLE   = 3'b001;
   localparam [2:0] ST_CONV   = 3'b010;
   localparam [2:0] ST_FINISH = 3'b100;

   localparam [2:0] LAST_BIT  = 3'd7;
   localparam [1:0] LAST_ICYC = 2'd3;

   localparam [RESULT_WIDTH-1:0] RESULT_ZERO = {RESULT_WIDTH{1'b0}};
   localparam [RESULT_WIDTH-1:0] TRIAL_TOP   = {1'b1, {(RESULT_WIDTH-1){1'b0}}};

   reg  [2:0]              state;
   reg  [1:0]              icyc;
   reg  [2:0]              bit_idx;
   reg  [RESULT_WIDTH-1:0] trial;
   reg  [RESULT_WIDTH-1:0] sar;
   reg  [PORT0_WIDTH-1:0]  p0_s1;
   reg  [PORT0_WIDTH-1:0]  p0_s2;
   reg  [PORT0_WIDTH-1:0]  p0_s3;
   reg                     cmp_s1;
   reg                     cmp_s2;
   reg                     cmp_s3;
   wire                    select_any;
   wire                    tick;

   assign select_any = choose_analog_input_zero_in | choose_analog_input_one_in;

   // ==========================================================
   // Instruction-cycle divider, realigned by a select
   acc_instr_tick #(
      .DIVIDE     (INSTR_CYCLE_CLKS)
   ) u_tick (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .restart_in (select_any),
      .tick_out   (tick)
   );

   // ==========================================================
   // Input synchronisers for comparator decisions
   // Port 0 second and third stages must agree before a change is accepted
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         p0_s1  <= {PORT0_WIDTH{1'b0}};
         p0_s2  <= {PORT0_WIDTH{1'b0}};
         p0_s3  <= {PORT0_WIDTH{1'b0}};
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         cmp_s3 <= 1'b0;
      end else begin
         p0_s1  <= port0_above_ref_in;
         p0_s2  <= p0_s1;
         p0_s3  <= p0_s2;
         cmp_s1 <= ladder_above_input_in;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
      end
   end

   // ==========================================================
   // Port 0 read value, per line against the shared reference
   genvar g;
   generate
      for (g = 0; g < PORT0_WIDTH; g = g + 1) begin : g_port0
         always @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
               port0_data_out[g] <= 1'b0;
            end else if (p0_s2[g] == p0_s3[g]) begin
               port0_data_out[g] <= p0_s3[g];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Channel select, only changed by the select strobes
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         channel_select_out <= `ACC_CHAN_ZERO;
      end else if (choose_analog_input_zero_in) begin
         channel_select_out <= `ACC_CHAN_ZERO;
      end else if (choose_analog_input_one_in) begin
         channel_select_out <= `ACC_CHAN_ONE;
      end
   end

   // ==========================================================
   // Successive approximation over four instruction cycles.
   // Eight trials are spread evenly: two per instruction cycle, the
   // second half-cycle trial taken when the divider reaches midway.
   wire half_tick;
   reg  [31:0] half_cnt;
   // Midway trial one clock early so trials sit evenly, four clocks apart at
   // the smallest divide: just enough for a ladder code to clear the synchroniser
   assign half_tick = (half_cnt == (INSTR_CYCLE_CLKS / 2) - 1);

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         half_cnt <= 32'h00000000;
      end else if (select_any || tick) begin
         half_cnt <= 32'h00000000;
      end else begin
         half_cnt <= half_cnt + 32'h00000001;
      end
   end

   // Trial step: decide current bit from the settled comparator
   wire step = tick | half_tick;

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state                     <= ST_IDLE;
         icyc                      <= 2'd0;
         bit_idx                   <= LAST_BIT;
         trial                     <= TRIAL_TOP;
         sar                       <= RESULT_ZERO;
         sample_out                <= 1'b0;
         ladder_code_out           <= TRIAL_TOP;
         conversion_result_reg_out <= `ACC_RESULT_RESET;
         result_fresh_out          <= 1'b0;
      end else if (select_any) begin
         // Abort and restart; the held result is left alone
         state            <= ST_CONV;
         icyc             <= 2'd0;
         bit_idx          <= LAST_BIT;
         trial            <= TRIAL_TOP;
         sar              <= RESULT_ZERO;
         sample_out       <= 1'b1;
         ladder_code_out  <= TRIAL_TOP;
         result_fresh_out <= 1'b0;
      end else begin
         sample_out       <= 1'b0;
         result_fresh_out <= 1'b0;
         case (state)
            ST_IDLE: begin
               state      <= ST_CONV;
               sample_out <= 1'b1;
            end
            ST_CONV: begin
               if (tick) begin
                  icyc <= icyc + 2'd1;
               end
               if (step) begin
                  // Keep the bit when the ladder is not above the input
                  if (!cmp_s3) begin
                     sar[bit_idx] <= 1'b1;
                  end
                  bit_idx         <= bit_idx - 3'd1;
                  ladder_code_out <= (cmp_s3 ? sar : (sar | trial)) | (trial >> 1);
                  trial           <= trial >> 1;
                  // Bit zero waits for the fourth boundary, where it posts
                  if (bit_idx == 3'd1) begin
                     state <= ST_FINISH;
                  end
               end
            end
            ST_FINISH: begin
               // Last trial decided and posted at once, at the fourth boundary
               if (tick && icyc == LAST_ICYC) begin
                  conversion_result_reg_out <= sar | {{(RESULT_WIDTH-1){1'b0}}, ~cmp_s3};
                  result_fresh_out          <= 1'b1;
                  state                     <= ST_CONV;
                  icyc                      <= 2'd0;
                  bit_idx                   <= LAST_BIT;
                  trial                     <= TRIAL_TOP;
                  sar                       <= RESULT_ZERO;
                  sample_out                <= 1'b1;
                  ladder_code_out           <= TRIAL_TOP;
               end else if (tick) begin
                  icyc <= icyc + 2'd1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Read instruction: copy the held result, conversion untouched
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         accumulator_data_out <= RESULT_ZERO;
         accumulator_load_out <= 1'b0;
      end else begin
         accumulator_load_out <= read_conversion_instr_in;
         if (read_conversion_instr_in) begin
            accumulator_data_out <= conversion_result_reg_out;
         end
      end
   end

endmodule

`default_nettype wire

// ### hdl/acc_instr_tick.v
// Instruction-cycle tick divider: one-cycle enable every N core clocks.
// Assumes a single core clock; restart realigns the tick phase.
`timescale 1ns/1ps
`default_nettype none

module acc_instr_tick #(
   parameter DIVIDE = 2000
) (
   // Clock and reset
   input  wire        clk_in,
   input  wire        reset_in,
   // Control
   input  wire        restart_in,
   // Tick
   output reg         tick_out
);

   reg [31:0] count;

   // ==========================================================
   // Divider
   // Restart counts the select clock itself, so every boundary lands a
   // whole number of instruction cycles after the select edge
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         count    <= 32'h00000000;
         tick_out <= 1'b0;
      end else if (restart_in) begin
         count    <= 32'h00000001;
         tick_out <= 1'b0;
      end else if (count == DIVIDE - 1) begin
         count    <= 32'h00000000;
         tick_out <= 1'b1;
      end else begin
         count    <= count + 32'h00000001;
         tick_out <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ### hdl/acc_map.vh
// Constants for the converter control block: timing, widths, encodings.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// ==========================================================
// Timing
`define ACC_CLK_PERIOD_PS     5000
`define ACC_INSTR_CYCLE_US    10
`define ACC_INSTR_CYCLE_CLKS  ((`ACC_INSTR_CYCLE_US * 1000000) / `ACC_CLK_PERIOD_PS)
`define ACC_CYCLES_PER_CONV   4

// ==========================================================
// Widths and values
`define ACC_RESULT_WIDTH      8
`define ACC_RESULT_RESET      8'h00
`define ACC_PORT0_WIDTH       8
`define ACC_CHAN_ZERO         1'b0
`define ACC_CHAN_ONE          1'b1

`endif

// ### verification/acc_converter_ctrl_checker.sv
// Checker for the converter control block, bound to its ports.
// Assumes one clock domain and an asynchronous high reset.
`timescale 1ns/1ps
`default_nettype none
// ==========
module acc_converter_ctrl_checker #(
   parameter int INSTR_CYCLE_CLKS = 8
) (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       choose_analog_input_zero_in,
   input  wire logic       choose_analog_input_one_in,
   input  wire logic       read_conversion_instr_in,
   input  wire logic [7:0] port0_above_ref_in,
   input  wire logic       channel_select_out,
   input  wire logic       sample_out,
   input  wire logic [7:0] ladder_code_out,
   input  wire logic [7:0] port0_data_out,
   input  wire logic [7:0] conversion_result_reg_out,
   input  wire logic [7:0] accumulator_data_out,
   input  wire logic       accumulator_load_out,
   input  wire logic       result_fresh_out
);
   localparam int CONV = 4 * INSTR_CYCLE_CLKS;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire         sel = choose_analog_input_zero_in | choose_analog_input_one_in;
   logic [15:0] since;
   logic        armed;
   // Clocks since the select or posting that began this conversion
   // A select counts from zero, a posting is seen one clock after it lands
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         since <= 16'h0;
         armed <= 1'b0;
      end else begin
         since <= sel ? 16'h0 : (result_fresh_out ? 16'h1 : since + 16'h1);
         armed <= armed | sel;
      end
   end
   a_chan_zero: assert property (choose_analog_input_zero_in |=> !channel_select_out)
      else $error("channel zero not selected");
   a_chan_one: assert property (
      choose_analog_input_one_in && !choose_analog_input_zero_in |=> channel_select_out)
      else $error("channel one not selected");
   a_restart_seq: assert property (sel |=> sample_out && ladder_code_out == 8'h80)
      else $error("select did not restart conversion");
   a_select_hold: assert property (sel |=> $stable(conversion_result_reg_out))
      else $error("select changed the result");
   a_load_whole: assert property ($changed(conversion_result_reg_out) |-> result_fresh_out)
      else $error("result changed without a posting");
   a_fresh_gap: assert property (armed && result_fresh_out |-> since == CONV)
      else $error("result posted at wrong time");
   a_fresh_due: assert property (armed && since == CONV && !sel |-> result_fresh_out)
      else $error("result posting missing");
   a_read_data: assert property (read_conversion_instr_in |=> accumulator_load_out && accumulator_data_out == $past(conversion_result_reg_out))
      else $error("read returned wrong data");
   a_load_cause: assert property (accumulator_load_out |-> $past(read_conversion_instr_in))
      else $error("accumulator load without read");
   a_port_follow: assert property ($stable(port0_above_ref_in) [*8] |-> port0_data_out == port0_above_ref_in)
      else $error("port 0 value does not follow comparators");
endmodule
bind acc_converter_ctrl acc_converter_ctrl_checker #(.INSTR_CYCLE_CLKS(INSTR_CYCLE_CLKS)) i_chk (
   .clk_in(clk_in), .reset_in(reset_in),
   .choose_analog_input_zero_in(choose_analog_input_zero_in),
   .choose_analog_input_one_in(choose_analog_input_one_in),
   .read_conversion_instr_in(read_conversion_instr_in),
   .port0_above_ref_in(port0_above_ref_in), .channel_select_out(channel_select_out),
   .sample_out(sample_out), .ladder_code_out(ladder_code_out), .port0_data_out(port0_data_out),
   .conversion_result_reg_out(conversion_result_reg_out),
   .accumulator_data_out(accumulator_data_out), .accumulator_load_out(accumulator_load_out),
   .result_fresh_out(result_fresh_out));
`default_nettype wire

// ### verification/acc_front_model.sv
// Analog front end model: ladder comparator over two channel levels.
// Assumes the controller drives mux select and trial code every clock.
`timescale 1ns/1ps
`default_nettype none
// ==========
module acc_front_model (
   // Controller side
   input  wire logic [7:0] ladder_code_in,
   input  wire logic       channel_select_in,
   // Levels of both analog inputs
   input  wire logic [7:0] level_zero_in,
   input  wire logic [7:0] level_one_in,
   // Decision, unsynchronised like the real comparator
   output logic            above_out
);
   // Ideal ladder, so the converted code equals the level
   assign above_out = ladder_code_in > (channel_select_in ? level_one_in : level_zero_in);
endmodule
`default_nettype wire

// ### verification/tb_adc_channel_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes the front end model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
// ==========
module tb_adc_channel_conversion_control;
   logic clk_in, reset_in, sel0, sel1, rd, above, chan, smp, load, fresh;
   logic [7:0] code, p0, p0_data, result, acc, lvl0, lvl1;
   logic [31:0] seed;
   logic exp_ch;
   int errors, compares, i;
   localparam int CONV = 4 * 8; // Four instruction cycles of 8 clocks
   acc_converter_ctrl #(.INSTR_CYCLE_CLKS(8)) i_dut (
      .clk_in(clk_in), .reset_in(reset_in), .choose_analog_input_zero_in(sel0),
      .choose_analog_input_one_in(sel1), .read_conversion_instr_in(rd),
      .ladder_above_input_in(above), .channel_select_out(chan), .sample_out(smp),
      .ladder_code_out(code), .port0_above_ref_in(p0), .port0_data_out(p0_data),
      .conversion_result_reg_out(result), .accumulator_data_out(acc),
      .accumulator_load_out(load), .result_fresh_out(fresh));
   acc_front_model i_front (.ladder_code_in(code), .channel_select_in(chan),
      .level_zero_in(lvl0), .level_one_in(lvl1), .above_out(above));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("Compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Model compares every posted result with the level of the chosen input
   always @(negedge clk_in)
      if (!reset_in && fresh === 1'b1)
         check("result", result, exp_ch ? lvl1 : lvl0);
   task automatic wait_fresh(input int exp_n);
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (fresh !== 1'b1 && n < 100);
      check("fresh seen", {7'h0, n < 100}, 8'h01);
      if (exp_n > 0)
         check("fresh delay", n[7:0], exp_n[7:0]);
   endtask
   // ch 2 raises both strobes at once; input zero must win
   task automatic choose(input int ch);
      logic [7:0] held;
      @(negedge clk_in);
      held = result;
      @(posedge clk_in);
      seed = xs(seed);
      if (ch == 1) lvl1 <= seed[7:0];
      else lvl0 <= seed[7:0];
      sel0 <= (ch != 1);
      sel1 <= (ch != 0);
      exp_ch = (ch == 1);
      @(posedge clk_in);
      sel0 <= 1'b0;
      sel1 <= 1'b0;
      @(negedge clk_in);
      check("channel", {7'h0, chan}, {7'h0, exp_ch});
      check("held result", result, held);
   endtask
   task automatic do_read();
      @(posedge clk_in);
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      @(negedge clk_in);
      check("acc data", acc, exp_ch ? lvl1 : lvl0);
      check("acc load", {7'h0, load}, 8'h01);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   // Whole run is a few hundred clocks
   initial begin
      #100000;
      errors++;
      $display("Error watchdog expected end seen hang");
      end_of_test();
   end
   initial begin
      {reset_in, sel0, sel1, rd, exp_ch} = 5'b10000;
      seed = 32'h3a80c431;
      {lvl0, lvl1, p0} = {8'h5a, 8'hc3, 8'h00};
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      wait_fresh(0);
      for (i = 0; i < 6; i++) begin
         choose(i % 3);
         wait_fresh(CONV);
         wait_fresh(CONV);
         do_read();
         @(posedge clk_in);
         seed = xs(seed);
         p0 <= seed[15:8];
         repeat (8) @(negedge clk_in);
         check("port0", p0_data, p0);
         $display("Test %0d done", i);
      end
      // Abort mid-conversion, then convert the other input
      choose(0);
      repeat (16) @(posedge clk_in);
      choose(1);
      wait_fresh(CONV);
      do_read();
      $display("Abort test done");
      end_of_test();
   end
endmodule
`default_nettype wire
